// *** rtl/qdac_dev.sv ***
// dac end: serial shift register, decode and dac registers
`timescale 1ns/1ns
`include "qdac_cfg.svh"
// ==========================================
// Notes on behaviour
// [R01] select low enables shifting of serial data
// [R02] sample data, shift on rising serial clock
// [R03] host sends address, code msb first, pads
// [R04] select rising edge loads addressed dac registers
// [R05] select high freezes the shift register
// [R06] host keeps serial clock low before select
// [R07] data out lags data in sixteen edges
// [R08] chained devices form one long register
// [R09] clear falling edge zeroes shift and dacs
// [R10] power up leaves all outputs zero
// [R11] code 1110 sleeps, code ignored, values kept
// [R12] a nop, single dac or all load wakes, others restored
// [R13] code is unsigned fraction of reference
// [R14] host resends sleep to keep chips asleep
// [R15] decode nop, single dac, sleep, all
// [R16] reserved codes change nothing
module qdac_dev #(
    parameter int CODE_W = `QDAC_CODE_W
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // link
    qdac_if.dev LINK,
    // dac codes, k of 1024 of reference
    output logic [CODE_W-1:0] DAC_A,
    output logic [CODE_W-1:0] DAC_B,
    output logic [CODE_W-1:0] DAC_C,
    output logic [CODE_W-1:0] DAC_D,
    output logic SLEEP,
    output logic LOAD_DONE
);
    // four converters share one shift register
    localparam int N_DAC = 4;

    // synchroniser stages
    logic [2:0] sck_s_q;
    logic [2:0] cs_s_q;
    logic [2:0] clr_s_q;
    logic din_m_q;
    logic din_s_q;

    // shift register, dac registers and flags
    logic [`QDAC_WORD_W-1:0] shift_q;
    logic [CODE_W-1:0] dac_q [N_DAC];
    logic sleep_q;
    logic done_q;
    logic dout_q;

    // edge strobes and word fields
    logic sck_rise;
    logic cs_rise;
    logic clr_fall;
    logic [`QDAC_ADDR_W-1:0] ac;
    logic [CODE_W-1:0] code;

    // ==========================================
    // pin synchronisers, third stage for edges
    // serial clock: resets low, its idle level, so no false rise
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sck_s_q <= 3'h0;
        end else begin
            sck_s_q <= {sck_s_q[1:0], LINK.sck};
        end
    end

    // select: resets high so no false load follows reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_s_q <= 3'h7;
        end else begin
            cs_s_q <= {cs_s_q[1:0], LINK.select_load_n};
        end
    end

    // clear: resets high so no false clear follows reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clr_s_q <= 3'h7;
        end else begin
            clr_s_q <= {clr_s_q[1:0], LINK.async_clear_n};
        end
    end

    // data in: two stages, in step with the second clock stage
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            din_m_q <= 1'b0;
            din_s_q <= 1'b0;
        end else begin
            din_m_q <= LINK.din;
            din_s_q <= din_m_q;
        end
    end

    // edge detection on second and third stages
    assign sck_rise = sck_s_q[1] & ~sck_s_q[2];
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    assign clr_fall = ~clr_s_q[1] & clr_s_q[2];
    assign ac = shift_q[`QDAC_ADDR_HI:`QDAC_ADDR_LO]; // [R03]
    assign code = shift_q[`QDAC_CODE_HI:`QDAC_CODE_LO]; // [R13]

    // ==========================================
    // shift register, data out from its far end
    // a clear in the same cycle as a rise wins
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_q <= `QDAC_WORD_ZERO;
        end else if (clr_fall) begin
            shift_q <= `QDAC_WORD_ZERO; // [R09]
        end else if (sck_rise && !cs_s_q[2]) begin // [R01] [R05]
            shift_q <= {shift_q[`QDAC_WORD_W-2:0], din_s_q}; // [R02]
        end
    end

    // data out: copy of the msb after the shift, sixteen rises behind
    // a chained device samples it before it moves, one stage per bit
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dout_q <= 1'b0;
        end else if (clr_fall) begin
            dout_q <= 1'b0;
        end else if (sck_rise && !cs_s_q[2]) begin
            dout_q <= shift_q[`QDAC_WORD_W-2]; // [R07] [R08]
        end
    end
    assign LINK.dout = dout_q;

    // ==========================================
    // dac registers and sleep decode on load
    // decode lives in functions so the dac and sleep processes agree

    // true when a load with this code writes dac idx
    function automatic logic hits_dac(logic [`QDAC_ADDR_W-1:0] a, int idx);
        logic [`QDAC_ADDR_W-1:0] own;
        own = `QDAC_AC_DAC_A + idx[`QDAC_ADDR_W-1:0];
        return (a == own) || (a == `QDAC_AC_ALL); // [R15]
    endfunction

    // true when a load with this code ends sleep
    function automatic logic wakes(logic [`QDAC_ADDR_W-1:0] a);
        logic w;
        case (a)
            `QDAC_AC_NOP, `QDAC_AC_DAC_A, `QDAC_AC_DAC_B, `QDAC_AC_DAC_C, `QDAC_AC_DAC_D, `QDAC_AC_ALL: begin
                w = 1'b1; // [R12]
            end
            default: begin
                w = 1'b0; // [R16]
            end
        endcase
        return w;
    endfunction

    // dac registers: zeroed by reset or clear, addressed ones take the code
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            for (int i = 0; i < N_DAC; i++) begin
                dac_q[i] <= `QDAC_CODE_ZERO; // [R10]
            end
        end else if (clr_fall) begin
            for (int i = 0; i < N_DAC; i++) begin
                dac_q[i] <= `QDAC_CODE_ZERO; // [R09]
            end
        end else if (cs_rise) begin // [R04]
            for (int i = 0; i < N_DAC; i++) begin
                if (hits_dac(ac, i)) begin
                    dac_q[i] <= code; // [R13]
                end
            end
        end
    end

    // sleep flag: a clear keeps it, reserved codes leave it alone
    // dacs not written keep their codes, so waking restores them
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sleep_q <= 1'b0;
        end else if (cs_rise && !clr_fall) begin
            if (ac == `QDAC_AC_SLEEP) begin
                sleep_q <= 1'b1; // [R11]
            end else if (wakes(ac)) begin
                sleep_q <= 1'b0; // [R12]
            end
        end
    end

    // load strobe, one cycle after each load
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            done_q <= 1'b0;
        end else begin
            done_q <= cs_rise & ~clr_fall;
        end
    end

    // ==========================================
    // outputs from flip-flops
    assign DAC_A = dac_q[0];
    assign DAC_B = dac_q[1];
    assign DAC_C = dac_q[2];
    assign DAC_D = dac_q[3];
    assign SLEEP = sleep_q;
    assign LOAD_DONE = done_q;
endmodule

// *** rtl/qdac_cfg.svh ***
// shared constants for the quad dac serial load link
`ifndef QDAC_CFG_SVH
`define QDAC_CFG_SVH
// ==========================================
// word layout
`define QDAC_WORD_W 16
`define QDAC_CODE_W 10
`define QDAC_ADDR_W 4
`define QDAC_ADDR_HI 15
`define QDAC_ADDR_LO 12
`define QDAC_CODE_HI 11
`define QDAC_CODE_LO 2
// ==========================================
// address/control codes
`define QDAC_AC_NOP 4'h0
`define QDAC_AC_DAC_A 4'h1
`define QDAC_AC_DAC_B 4'h2
`define QDAC_AC_DAC_C 4'h3
`define QDAC_AC_DAC_D 4'h4
`define QDAC_AC_SLEEP 4'he
`define QDAC_AC_ALL 4'hf
// ==========================================
// host timing and zero constants
`define QDAC_SCK_HALF 8
`define QDAC_CNT_W 5
`define QDAC_CODE_ZERO 10'h000
`define QDAC_WORD_ZERO 16'h0000
`endif

// *** rtl/qdac_pkg.sv ***
// types for the quad dac serial load link
package qdac_pkg;
    // ==========================================
    // host sequencer states
    typedef enum logic [1:0] {QDAC_IDLE, QDAC_SHIFT, QDAC_LOAD} qdac_hstate_t;
endpackage

// *** rtl/qdac_if.sv ***
// five-wire link between host and dac
`timescale 1ns/1ns
interface qdac_if;
    logic sck;
    logic din;
    logic select_load_n;
    logic dout;
    logic async_clear_n;
    modport host (output sck, output din, output select_load_n, output async_clear_n, input dout);
    modport dev (input sck, input din, input select_load_n, input async_clear_n, output dout);
endinterface

// *** rtl/qdac_host.sv ***
// host end: sends one 16-bit word per request, then strobes load
`timescale 1ns/1ns
`include "qdac_cfg.svh"
module qdac_host #(
    parameter int HALF = `QDAC_SCK_HALF
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // user side: word request, ready stalls source
    input wire logic [`QDAC_WORD_W-1:0] WORD,
    input wire logic WORD_VALID,
    output logic WORD_READY,
    input wire logic CLEAR_REQ,
    output logic BUSY,
    // link
    qdac_if.host LINK
);
    logic [`QDAC_WORD_W-1:0] buf_q [2];
    logic [1:0] cnt_q;
    logic wp_q;
    logic rp_q;
    qdac_pkg::qdac_hstate_t st_q;
    logic [`QDAC_WORD_W-1:0] tx_q;
    logic [`QDAC_CNT_W-1:0] bits_q;
    logic [7:0] div_q;
    logic sck_q;
    logic cs_n_q;
    logic clr_n_q;
    logic rdy_q;
    logic busy_q;
    logic push;
    logic pop;

    // ==========================================
    // two-entry buffer in front of the shifter
    assign push = WORD_VALID & rdy_q;
    assign pop = (st_q == qdac_pkg::QDAC_IDLE) & (cnt_q != 2'h0);
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cnt_q <= 2'h0;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            rdy_q <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                buf_q[i] <= `QDAC_WORD_ZERO;
            end
        end else begin
            if (push) begin
                buf_q[wp_q] <= WORD;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= 2'(cnt_q + {1'b0, push} - {1'b0, pop});
            rdy_q <= (2'(cnt_q + {1'b0, push} - {1'b0, pop}) < 2'h2);
        end
    end
    assign WORD_READY = rdy_q;

    // ==========================================
    // shifter: sck low before select, msb first
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= qdac_pkg::QDAC_IDLE;
            tx_q <= `QDAC_WORD_ZERO;
            bits_q <= '0;
            div_q <= 8'h00;
            sck_q <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            case (st_q)
                qdac_pkg::QDAC_IDLE: begin
                    sck_q <= 1'b0; // [R06]
                    div_q <= 8'h00;
                    if (pop) begin
                        tx_q <= buf_q[rp_q];
                        bits_q <= `QDAC_CNT_W'(`QDAC_WORD_W);
                        cs_n_q <= 1'b0;
                        st_q <= qdac_pkg::QDAC_SHIFT;
                    end
                end
                qdac_pkg::QDAC_SHIFT: begin
                    if (div_q == 8'(HALF - 1)) begin
                        div_q <= 8'h00;
                        if (!sck_q) begin
                            if (bits_q == '0) begin
                                st_q <= qdac_pkg::QDAC_LOAD;
                            end else begin
                                sck_q <= 1'b1;
                            end
                        end else begin
                            sck_q <= 1'b0;
                            tx_q <= {tx_q[`QDAC_WORD_W-2:0], 1'b0}; // [R03]
                            bits_q <= 5'(bits_q - 5'h01);
                        end
                    end else begin
                        div_q <= 8'(div_q + 8'h01);
                    end
                end
                qdac_pkg::QDAC_LOAD: begin
                    cs_n_q <= 1'b1; // [R04]
                    if (div_q == 8'(HALF - 1)) begin
                        st_q <= qdac_pkg::QDAC_IDLE;
                    end else begin
                        div_q <= 8'(div_q + 8'h01);
                    end
                end
                default: begin
                    st_q <= qdac_pkg::QDAC_IDLE;
                end
            endcase
        end
    end

    // clear pulse while idle, never in the cycle a frame starts
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clr_n_q <= 1'b1;
        end else begin
            clr_n_q <= ~(CLEAR_REQ & (st_q == qdac_pkg::QDAC_IDLE) & ~pop);
        end
    end

    // busy flag, set with the frame start, dropped when back to idle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            busy_q <= 1'b0;
        end else if (pop) begin
            busy_q <= 1'b1;
        end else if ((st_q == qdac_pkg::QDAC_LOAD) && (div_q == 8'(HALF - 1))) begin
            busy_q <= 1'b0;
        end
    end

    assign LINK.sck = sck_q;
    assign LINK.din = tx_q[`QDAC_WORD_W-1];
    assign LINK.select_load_n = cs_n_q;
    assign LINK.async_clear_n = clr_n_q;
    assign BUSY = busy_q;
endmodule

// *** bench/qdac_assertions.sv ***
// link checker for the quad dac serial load link
`timescale 1ns/1ns
module qdac_assertions (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // link
    input wire logic sck,
    input wire logic din,
    input wire logic select_load_n,
    input wire logic dout,
    input wire logic async_clear_n
);
    // ==========================================
    // reference shift chain of the link
    logic sck_q;
    logic [15:0] sh_q;
    logic [4:0] cnt_q;
    // far end of the shadow chain is the bit expected on dout
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sck_q <= 1'b0;
            sh_q <= 16'h0000;
        end else begin
            sck_q <= sck;
            if (!async_clear_n) begin
                sh_q <= 16'h0000;
            end else if (sck && !sck_q && !select_load_n) begin
                sh_q <= {sh_q[14:0], din};
            end
        end
    end
    // rises within the current frame
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N)
            cnt_q <= 5'h00;
        else if (select_load_n)
            cnt_q <= 5'h00;
        else if (sck && !sck_q)
            cnt_q <= cnt_q + 5'h01;
    end
    // ==========================================
    // assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    chk_idle_sck_low: assert property (select_load_n |-> !sck)
        else $error("sck high while deselected");
    chk_first_rise: assert property ($fell(select_load_n) |-> ##[1:16] $rose(sck))
        else $error("no sck rise after select");
    chk_sck_high_span: assert property ($rose(sck) |-> sck[*8] ##1 !sck)
        else $error("sck high span wrong");
    chk_din_hold: assert property (sck |-> $stable(din))
        else $error("din moved while sck high");
    chk_frame_len: assert property ($rose(select_load_n) |-> cnt_q == 5'h10)
        else $error("frame not sixteen bits");
    chk_sel_gap: assert property ($rose(select_load_n) |=> select_load_n[*7])
        else $error("select high too short");
    chk_clear_idle: assert property (!async_clear_n |-> select_load_n && !sck)
        else $error("clear inside a frame");
    chk_dout_lag: assert property ($fell(sck) |-> dout == sh_q[15])
        else $error("dout lag wrong");
    cov_load: cover property ($rose(select_load_n));
    cov_clear: cover property ($fell(async_clear_n));
    cov_dout_one: cover property ($fell(sck) && dout);
endmodule

// *** bench/quad_dac_serial_load_interface_bench.sv ***
// self-checking bench: host and dac joined over the link
`timescale 1ns/1ns
module quad_dac_serial_load_interface_bench;
    // ==========================================
    // signals and model state
    logic clk;
    logic reset_n;
    logic [15:0] word;
    logic word_valid;
    logic word_ready;
    logic clear_req;
    logic busy;
    logic [9:0] dac[4];
    logic sleep;
    logic load_done;
    logic [9:0] exp_dac[4];
    logic exp_sleep;
    logic [31:0] seed = 32'h0000c886;
    int n_errors = 0;
    int n_compared = 0;
    int n_loads = 0;
    int n_sent = 0;
    localparam logic [15:0] CORNER[10] = '{16'h1ffc, 16'h2004, 16'h3aa8, 16'h4554, 16'he3fc,
        16'h5123, 16'h0000, 16'hf800, 16'he000, 16'h3004};
    // both ends and the checker
    qdac_if qdac_if_i ();
    qdac_host qdac_host_i (.CLK(clk), .RESET_N(reset_n), .WORD(word), .WORD_VALID(word_valid),
        .WORD_READY(word_ready), .CLEAR_REQ(clear_req), .BUSY(busy), .LINK(qdac_if_i.host));
    qdac_dev qdac_dev_i (.CLK(clk), .RESET_N(reset_n), .LINK(qdac_if_i.dev), .DAC_A(dac[0]),
        .DAC_B(dac[1]), .DAC_C(dac[2]), .DAC_D(dac[3]), .SLEEP(sleep), .LOAD_DONE(load_done));
    qdac_assertions qdac_assertions_i (.CLK(clk), .RESET_N(reset_n), .sck(qdac_if_i.sck),
        .din(qdac_if_i.din), .select_load_n(qdac_if_i.select_load_n), .dout(qdac_if_i.dout),
        .async_clear_n(qdac_if_i.async_clear_n));
    // ==========================================
    // helpers
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // expected dacs and sleep after one load
    function automatic void model(logic [15:0] w);
        logic [3:0] a = w[15:12];
        if (a >= 4'h1 && a <= 4'h4) exp_dac[a - 4'h1] = w[11:2];
        if (a == 4'hf) exp_dac = '{4{w[11:2]}};
        if (a <= 4'h4 || a == 4'hf) exp_sleep = 1'b0;
        if (a == 4'he) exp_sleep = 1'b1;
    endfunction
    task automatic check(string name, logic [15:0] seen, logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", name, want, seen);
        end
    endtask
    // offer a word, valid stays up until taken
    task automatic send(logic [15:0] w);
        word = w;
        word_valid = 1'b1;
        for (int i = 0; i < 2000 && word_ready !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        model(w);
        n_sent++;
    endtask
    // wait for every load, then compare
    task automatic settle();
        word_valid = 1'b0;
        for (int i = 0; i < 3000 && n_loads != n_sent; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        for (int i = 0; i < 4; i++) check("dac", {6'h00, dac[i]}, {6'h00, exp_dac[i]});
        check("sleep", {15'h0000, sleep}, {15'h0000, exp_sleep});
        check("loads", n_loads[15:0], n_sent[15:0]);
    endtask
    task automatic clear();
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        clear_req = 1'b1;
        repeat (3) @(negedge clk);
        clear_req = 1'b0;
        exp_dac = '{4{10'h000}};
        settle();
    endtask
    task automatic print_verdict();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // clock, load counter, watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) if (load_done === 1'b1) n_loads++;
    initial begin
        #300000;
        n_errors++;
        print_verdict();
    end
    // main sequence: corners in two back-to-back runs, then random batches
    initial begin
        reset_n = 1'b0;
        word = 16'h0000;
        word_valid = 1'b0;
        clear_req = 1'b0;
        exp_dac = '{4{10'h000}};
        exp_sleep = 1'b0;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        settle();
        foreach (CORNER[i]) begin
            send(CORNER[i]);
            if (i == 5 || i == 9) settle();
        end
        send(16'he155);
        send(16'he2aa);
        settle();
        for (int b = 0; b < 14; b++) begin
            for (int k = 0; k <= b % 3; k++) begin
                seed = xs(seed);
                send(seed[15:0]);
            end
            settle();
            if (b % 5 == 4) clear();
        end
        print_verdict();
    end
endmodule
